/* rpp_pkg.sv */
/*
  package of the read prefetch policy block: register offsets, field positions,
  reset value, command codes, bus response codes and the sequencer state type.
  assumes nothing beyond a SystemVerilog compiler.
*/
package rpp_pkg;

  // register map (byte addresses)
  localparam logic [7:0]  RPP_OFF_POLICY       = 8'h4c;
  localparam logic [7:0]  RPP_OFF_STATUS       = 8'h50;
  localparam logic [31:0] RPP_POLICY_RESET     = 32'h00002c00;
  localparam logic [31:0] RPP_POLICY_WMASK     = 32'h00003ffc;

  // field positions in the policy register
  localparam int RPP_CPF_MRM_BIT = 13;
  localparam int RPP_INITIAL_PREFETCH_CNT_READ_MULTIPLE_LSB = 10;
  localparam int RPP_CPF_MRL_BIT = 9;
  localparam int RPP_INITIAL_PREFETCH_CNT_READ_LINE_LSB = 6;
  localparam int RPP_CPF_MR_BIT  = 5;
  localparam int RPP_INITIAL_PREFETCH_CNT_PLAIN_READ_LSB  = 2;
  localparam int RPP_IPF_W       = 3;

  // conventional pci read command codes
  localparam logic [3:0] RPP_CMD_MR  = 4'h6;
  localparam logic [3:0] RPP_CMD_MRL = 4'he;
  localparam logic [3:0] RPP_CMD_MRM = 4'hc;

  // axi responses
  localparam logic [1:0] RPP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RPP_RESP_SLVERR = 2'h2;

  // sequencer states, gray along idle -> first -> extra -> stream
  typedef enum logic [1:0] {
    RPP_IDLE   = 2'b00,
    RPP_FIRST  = 2'b01,
    RPP_EXTRA  = 2'b11,
    RPP_STREAM = 2'b10
  } rpp_state_e;

endpackage

/* rpp_class_sel.sv */
/*
  command class selector: picks the prefetch count and continuous enable that
  belong to the pci read command, and says whether the command qualifies.
  assumes a policy word laid out as in rpp_pkg; purely combinational.
*/
`timescale 1ns/1ps
module rpp_class_sel
  import rpp_pkg::*;
(
  // policy and command
  input  wire logic [31:0]          policy,
  input  wire logic [3:0]           cmd,
  // selected class
  output logic                      qualifies,
  output logic [RPP_IPF_W-1:0]      init_cnt,
  output logic                      cont_en
);

  wire logic is_mrm = (cmd == RPP_CMD_MRM);
  wire logic is_mrl = (cmd == RPP_CMD_MRL);
  wire logic is_mr  = (cmd == RPP_CMD_MR);

  assign qualifies = is_mrm | is_mrl | is_mr;
  assign init_cnt  = is_mrm ? policy[RPP_INITIAL_PREFETCH_CNT_READ_MULTIPLE_LSB +: RPP_IPF_W] :
                     is_mrl ? policy[RPP_INITIAL_PREFETCH_CNT_READ_LINE_LSB +: RPP_IPF_W] :
                     is_mr  ? policy[RPP_INITIAL_PREFETCH_CNT_PLAIN_READ_LSB  +: RPP_IPF_W] : '0;
  assign cont_en   = is_mrm ? policy[RPP_CPF_MRM_BIT] :
                     is_mrl ? policy[RPP_CPF_MRL_BIT] :
                     is_mr  ? policy[RPP_CPF_MR_BIT]  : 1'b0;

endmodule

/* rpp_axil_regs.sv */
/*
  axi4-lite slave holding the prefetch policy register and a read-only status
  word. assumes one outstanding write and one outstanding read per master.
*/
`timescale 1ns/1ps
module rpp_axil_regs
  import rpp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // block side
  output logic [31:0]      policy,
  input  wire logic [31:0] status
);

  logic [7:0]  aw_reg;
  logic        aw_have_reg;
  logic [31:0] w_reg;
  logic [3:0]  ws_reg;
  logic        w_have_reg;
  logic [31:0] policy_reg;

  wire logic        aw_take  = awvalid & awready;
  wire logic        w_take   = wvalid & wready;
  wire logic        do_write = aw_have_reg & w_have_reg & ~bvalid;
  wire logic        wr_hit   = (aw_reg == RPP_OFF_POLICY);
  wire logic [31:0] bytemask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
  wire logic [31:0] wmask    = bytemask & RPP_POLICY_WMASK;
  wire logic        rd_pol   = (araddr == RPP_OFF_POLICY);
  wire logic        rd_sts   = (araddr == RPP_OFF_STATUS);
  wire logic [31:0] rd_val   = rd_pol ? policy_reg : rd_sts ? status : 32'h00000000;

  assign policy  = policy_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_reg      <= 8'h00;
      aw_have_reg <= 1'b0;
      w_reg       <= 32'h00000000;
      ws_reg      <= 4'h0;
      w_have_reg  <= 1'b0;
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= RPP_RESP_OKAY;
      policy_reg  <= RPP_POLICY_RESET;
    end else begin
      if (aw_take) begin
        aw_reg      <= awaddr;
        aw_have_reg <= 1'b1;
        awready     <= 1'b0;
      end
      if (w_take) begin
        w_reg      <= wdata;
        ws_reg     <= wstrb;
        w_have_reg <= 1'b1;
        wready     <= 1'b0;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        awready     <= 1'b1;
        wready      <= 1'b1;
        bvalid      <= 1'b1;
        bresp       <= (wr_hit || aw_reg == RPP_OFF_STATUS) ? RPP_RESP_OKAY : RPP_RESP_SLVERR;
        if (wr_hit) begin
          policy_reg <= (policy_reg & ~wmask) | (w_reg & wmask);
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
      rdata   <= 32'h00000000;
      rresp   <= RPP_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid  <= 1'b1;
      arready <= 1'b0;
      rdata  <= rd_val;
      rresp  <= (rd_pol || rd_sts) ? RPP_RESP_OKAY : RPP_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

/* rpp_top.sv */
/*
  read prefetch policy of one pci bridge: on a qualifying master read it issues
  upstream line requests (partial first line, a programmed batch of extra lines,
  then one per line that starts transferring when continuous mode is set).
  assumes the request sink answers with req_ready, and the bridge front end
  reports a new read with rd_start and each line start with line_start.
*/
`timescale 1ns/1ps
module rpp_top
  import rpp_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int LINE_W = 6
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // axi4-lite register bus
  input  wire logic [7:0]        s_awaddr,
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  output logic [1:0]             s_bresp,
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  input  wire logic [7:0]        s_araddr,
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  // bridge mode and pci master side
  input  wire logic              pcix_mode,
  input  wire logic              master_prefetch_enable_n,
  input  wire logic              rd_start,
  input  wire logic [3:0]        rd_cmd,
  input  wire logic [ADDR_W-1:0] rd_addr,
  input  wire logic              line_start,
  input  wire logic              rd_done,
  // upstream line requests
  output logic                   req_valid,
  input  wire logic              req_ready,
  output logic [ADDR_W-1:0]      req_addr,
  output logic [LINE_W:0]        req_bytes,
  output logic                   req_unrequested,
  output logic                   busy
);

  localparam logic [LINE_W:0] LINE_BYTES = (LINE_W+1)'(1) << LINE_W;

  logic [31:0]          policy;
  logic                 qualifies;
  logic [RPP_IPF_W-1:0] init_cnt;
  logic                 cont_en;

  rpp_state_e           state_reg;
  rpp_state_e           state_next;
  logic [RPP_IPF_W-1:0] extra_reg;
  logic                 cont_reg;
  logic [7:0]           credit_reg;
  logic [ADDR_W-1:0]    next_line_reg;
  logic [ADDR_W-1:0]    first_addr_reg;

  rpp_class_sel u_sel (
    .policy    (policy),
    .cmd       (rd_cmd),
    .qualifies (qualifies),
    .init_cnt  (init_cnt),
    .cont_en   (cont_en)
  );

  wire logic [31:0] status_word = {26'h0, cont_reg, extra_reg, state_reg};

  rpp_axil_regs u_regs (
    .clk     (clk),
    .arst_n  (arst_n),
    .awaddr  (s_awaddr),
    .awvalid (s_awvalid),
    .awready (s_awready),
    .wdata   (s_wdata),
    .wstrb   (s_wstrb),
    .wvalid  (s_wvalid),
    .wready  (s_wready),
    .bresp   (s_bresp),
    .bvalid  (s_bvalid),
    .bready  (s_bready),
    .araddr  (s_araddr),
    .arvalid (s_arvalid),
    .arready (s_arready),
    .rdata   (s_rdata),
    .rresp   (s_rresp),
    .rvalid  (s_rvalid),
    .rready  (s_rready),
    .policy  (policy),
    .status  (status_word)
  );

  // start only in conventional mode, with master enabled and a read command
  wire logic start_ok   = rd_start & ~pcix_mode & ~master_prefetch_enable_n & qualifies;
  wire logic idle       = (state_reg == RPP_IDLE);
  wire logic take       = req_valid & req_ready;
  wire logic [LINE_W-1:0] offs = rd_addr[LINE_W-1:0];
  wire logic [ADDR_W-1:0] line_base = {rd_addr[ADDR_W-1:LINE_W], {LINE_W{1'b0}}};
  wire logic [ADDR_W-1:0] line_step = ADDR_W'(LINE_BYTES);
  wire logic [LINE_W:0]   first_len = LINE_BYTES - (LINE_W+1)'(offs);
  wire logic credit_inc = (state_reg != RPP_IDLE) & cont_reg & line_start;
  wire logic credit_dec = (state_reg == RPP_STREAM) & take;
  wire logic credit_any = (credit_reg != 8'h00);
  wire logic abort      = rd_done | pcix_mode;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RPP_IDLE: begin
        if (start_ok) state_next = RPP_FIRST;
      end
      RPP_FIRST: begin
        if (take) state_next = (extra_reg != '0) ? RPP_EXTRA : RPP_STREAM;
      end
      RPP_EXTRA: begin
        if (take && extra_reg == RPP_IPF_W'(1)) state_next = RPP_STREAM;
      end
      RPP_STREAM: begin
        state_next = RPP_STREAM;
      end
      default: state_next = RPP_IDLE;
    endcase
    // a new read wins over the end of the previous one only when the sequencer is idle
    if (abort && !req_valid && !(idle && start_ok)) state_next = RPP_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= RPP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extra_reg      <= '0;
      cont_reg       <= 1'b0;
      next_line_reg  <= '0;
      first_addr_reg <= '0;
    end else if (idle && start_ok) begin
      extra_reg      <= init_cnt;
      cont_reg       <= cont_en;
      first_addr_reg <= rd_addr;
      next_line_reg  <= line_base + line_step;
    end else if (take && state_reg != RPP_FIRST) begin
      next_line_reg <= next_line_reg + line_step;
      if (state_reg == RPP_EXTRA) extra_reg <= extra_reg - RPP_IPF_W'(1);
    end
  end

  // credits for continuous mode; stays zero when disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      credit_reg <= 8'h00;
    end else if (idle) begin
      credit_reg <= 8'h00;
    end else if (credit_inc && !credit_dec && credit_reg != 8'hff) begin
      credit_reg <= credit_reg + 8'h01;
    end else if (credit_dec && !credit_inc) begin
      credit_reg <= credit_reg - 8'h01;
    end
  end

  // request launch: a pending request is held until req_ready
  wire logic launch_first  = idle & start_ok;
  wire logic launch_extra  = (state_next == RPP_EXTRA) & ~(req_valid & ~take);
  wire logic launch_stream = (state_next == RPP_STREAM) & ~abort &
                             ((credit_any & ~credit_dec) | (credit_reg > 8'h01) | credit_inc) &
                             ~(req_valid & ~take);
  wire logic launch_more   = (launch_extra | launch_stream) & ~launch_first &
                             (state_reg != RPP_IDLE) & (take | ~req_valid);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_valid       <= 1'b0;
      req_addr        <= '0;
      req_bytes       <= '0;
      req_unrequested <= 1'b0;
    end else if (launch_first) begin
      req_valid       <= 1'b1;
      req_addr        <= rd_addr;
      req_bytes       <= first_len;
      req_unrequested <= 1'b0;
    end else if (launch_more && (state_reg != RPP_EXTRA || extra_reg != RPP_IPF_W'(1) || !take ||
                 cont_reg)) begin
      req_valid       <= launch_extra | (credit_any | credit_inc);
      req_addr        <= take ? ((state_reg == RPP_FIRST) ? next_line_reg :
                                  next_line_reg + line_step) : next_line_reg;
      req_bytes       <= LINE_BYTES;
      req_unrequested <= 1'b1;
    end else if (take) begin
      req_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_next != RPP_IDLE);
    end
  end

  // a first request always carries the start address and reaches the line end
  a_first_partial_line: assert property (@(posedge clk) disable iff (!arst_n)
    idle && start_ok |=> req_valid && !req_unrequested &&
      (req_bytes + (LINE_W+1)'(req_addr[LINE_W-1:0]) == LINE_BYTES))
    else $error("first request does not end at the line boundary");

  a_pcix_no_start: assert property (@(posedge clk) disable iff (!arst_n)
    idle && rd_start && pcix_mode |=> idle)
    else $error("prefetch started in pci-x mode");

  a_disabled_master: assert property (@(posedge clk) disable iff (!arst_n)
    idle && rd_start && master_prefetch_enable_n |=> !req_valid)
    else $error("prefetch for a disabled master");

  sequence s_first_taken;
    state_reg == RPP_FIRST && take;
  endsequence

  a_batch_start: assert property (@(posedge clk) disable iff (!arst_n)
    s_first_taken and extra_reg != '0 |=> state_reg == RPP_EXTRA)
    else $error("extra lines not requested");

  a_zero_count: assert property (@(posedge clk) disable iff (!arst_n)
    s_first_taken and extra_reg == '0 |=> state_reg == RPP_STREAM)
    else $error("extra lines requested with zero count");

  a_extra_unreq: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && state_reg == RPP_EXTRA |-> req_unrequested && req_bytes == LINE_BYTES)
    else $error("extra line not marked unrequested");

  a_no_cont_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == RPP_STREAM && !cont_reg && !req_valid |=> !req_valid)
    else $error("request after batch with continuous mode off");

  a_cont_credit: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == RPP_STREAM && cont_reg && line_start && !req_valid && !abort |=> req_valid)
    else $error("line start did not request a new line");

  a_count_load: assert property (@(posedge clk) disable iff (!arst_n)
    idle && start_ok |=> extra_reg == $past(init_cnt))
    else $error("initial count not loaded");

  sequence s_extra_taken;
    state_reg == RPP_EXTRA && take;
  endsequence

  sequence s_stream_taken;
    state_reg == RPP_STREAM && take;
  endsequence

  a_req_hold: assert property (@(posedge clk) disable iff (!arst_n)
    req_valid && !req_ready |=> req_valid && $stable(req_addr) && $stable(req_bytes) &&
      $stable(req_unrequested))
    else $error("request changed before it was taken");

  a_extra_step: assert property (@(posedge clk) disable iff (!arst_n)
    s_extra_taken and extra_reg != RPP_IPF_W'(1) |=>
      req_valid && req_unrequested && req_addr == $past(req_addr) + line_step)
    else $error("extra line not at the next address");

  a_last_extra: assert property (@(posedge clk) disable iff (!arst_n)
    s_extra_taken and extra_reg == RPP_IPF_W'(1) && !cont_reg |=>
      state_reg == RPP_STREAM && !req_valid)
    else $error("request after the last extra line");

  a_stream_step: assert property (@(posedge clk) disable iff (!arst_n)
    s_stream_taken and (credit_inc || credit_reg > 8'h01) && !abort |=>
      req_valid && req_unrequested && req_addr == $past(req_addr) + line_step)
    else $error("credited line not requested");

  a_pcix_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    pcix_mode && !req_valid |=> idle && !req_valid)
    else $error("activity in pci-x mode");

  a_masked_master: assert property (@(posedge clk) disable iff (!arst_n)
    idle && master_prefetch_enable_n |=> idle && !req_valid)
    else $error("count used for a disabled master");

  a_busy_flag: assert property (@(posedge clk) disable iff (!arst_n)
    idle |=> busy == $past(start_ok))
    else $error("busy does not follow a read start");

  a_credit_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    !cont_reg |-> credit_reg == 8'h00)
    else $error("credit counted with continuous mode off");

endmodule

/* rpp_sink_model.sv */
/*
  upstream request sink: takes line requests from the block and logs them.
  assumes the block holds req_* until req_ready; slow makes ready come every third cycle.
*/
`timescale 1ns/1ps
module rpp_sink_model #(
  parameter int ADDR_W = 32,
  parameter int LINE_W = 6
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // request link
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [LINE_W:0]   req_bytes,
  input  wire logic              req_unrequested,
  output logic                   req_ready,
  // pacing
  input  wire logic              slow
);
  logic [ADDR_W-1:0] addr_q  [64];
  logic [LINE_W:0]   bytes_q [64];
  logic              unreq_q [64];
  int                cnt_reg;
  logic [1:0]        ph_reg;

  assign req_ready = !slow || (ph_reg == 2'h2);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg  <= 2'h0;
      cnt_reg <= 0;
    end else begin
      ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
      if (req_valid && req_ready && cnt_reg < 64) begin
        addr_q[cnt_reg]  <= req_addr;
        bytes_q[cnt_reg] <= req_bytes;
        unreq_q[cnt_reg] <= req_unrequested;
        cnt_reg          <= cnt_reg + 1;
      end
    end
  end
endmodule

/* pci_read_prefetch_policy_tb_top.sv */
/*
  testbench of rpp_top: axi4-lite register tasks, pci read stimulus, request checks.
  assumes rpp_sink_model on the request link; 64-byte lines.
*/
`timescale 1ns/1ps
module pci_read_prefetch_policy_tb_top;
  import rpp_pkg::*;
  logic        clk, arst_n;
  logic [7:0]  s_awaddr, s_araddr;
  logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic [31:0] s_wdata, s_rdata, rd_d;
  logic [3:0]  s_wstrb, rd_cmd;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic        pcix_mode, master_prefetch_enable_n, rd_start, line_start, rd_done;
  logic [31:0] rd_addr, req_addr;
  logic        req_valid, req_ready, req_unrequested, busy, slow;
  logic [6:0]  req_bytes;
  int          error_cnt, tests_run;

  rpp_top dut (.clk(clk), .arst_n(arst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .pcix_mode(pcix_mode),
    .master_prefetch_enable_n(master_prefetch_enable_n), .rd_start(rd_start), .rd_cmd(rd_cmd),
    .rd_addr(rd_addr), .line_start(line_start), .rd_done(rd_done), .req_valid(req_valid),
    .req_ready(req_ready), .req_addr(req_addr), .req_bytes(req_bytes),
    .req_unrequested(req_unrequested), .busy(busy));
  rpp_sink_model sink (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_addr(req_addr),
    .req_bytes(req_bytes), .req_unrequested(req_unrequested), .req_ready(req_ready),
    .slow(slow));

  always #12.5 clk = ~clk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hf);
    int k;
    bit done;
    done = 0;
    @(posedge clk);
    s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wstrb <= st; s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (k = 0; k < 100 && !done; k++) begin
      @(posedge clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        rsp = s_bresp; s_bready <= 1'b0; done = 1;
      end
    end
    if (!done) begin error_cnt++; results(); end
  endtask

  task automatic axr(input logic [7:0] a);
    int k;
    bit done;
    done = 0;
    @(posedge clk);
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    for (k = 0; k < 100 && !done; k++) begin
      @(posedge clk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        rd_d = s_rdata; rsp = s_rresp; s_rready <= 1'b0; done = 1;
      end
    end
    if (!done) begin error_cnt++; results(); end
  endtask

  task automatic wait_n(input int t);
    int k;
    for (k = 0; k < 400 && sink.cnt_reg < t; k++) @(posedge clk);
    if (sink.cnt_reg < t) begin error_cnt++; results(); end
  endtask

  // one master read: n_init requests expected at once, n_tot after ls line starts
  task automatic run(input logic [3:0] c, input logic [31:0] a, input logic en_n,
                     input logic pm, input int ls, input int n_init, input int n_tot);
    int s0, i, k;
    logic [31:0] base;
    s0 = sink.cnt_reg;
    base = {a[31:6], 6'h00};
    @(posedge clk);
    master_prefetch_enable_n <= en_n; pcix_mode <= pm;
    rd_cmd <= c; rd_addr <= a; rd_start <= 1'b1;
    @(posedge clk);
    rd_start <= 1'b0;
    wait_n(s0 + n_init);
    for (i = 0; i < ls; i++) begin
      @(posedge clk) line_start <= 1'b1;
      @(posedge clk) line_start <= 1'b0;
    end
    wait_n(s0 + n_tot);
    repeat (20) @(posedge clk);
    chk(32'(sink.cnt_reg - s0), 32'(n_tot));
    chk(32'(busy), n_tot > 0 ? 32'h1 : 32'h0);
    for (i = 0; i < n_tot; i++) begin
      chk(sink.addr_q[s0+i], i == 0 ? a : base + 32'(64 * i));
      chk(32'(sink.bytes_q[s0+i]), i == 0 ? 32'd64 - 32'(a[5:0]) : 32'd64);
      chk(32'(sink.unreq_q[s0+i]), i == 0 ? 32'h0 : 32'h1);
    end
    @(posedge clk) rd_done <= 1'b1;
    @(posedge clk) rd_done <= 1'b0;
    for (k = 0; k < 50 && busy !== 1'b0; k++) @(posedge clk);
    chk(32'(busy), 32'h0);
    if (busy !== 1'b0) results();
  endtask

  initial begin
    clk = 0; arst_n = 0; slow = 0;
    s_awaddr = 0; s_awvalid = 0; s_wdata = 0; s_wstrb = 0; s_wvalid = 0; s_bready = 0;
    s_araddr = 0; s_arvalid = 0; s_rready = 0;
    pcix_mode = 0; master_prefetch_enable_n = 0; rd_start = 0; rd_cmd = 0; rd_addr = 0;
    line_start = 0; rd_done = 0; error_cnt = 0; tests_run = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    axr(RPP_OFF_POLICY);
    chk(rd_d, RPP_POLICY_RESET);
    axr(RPP_OFF_STATUS);
    chk(rd_d, 32'h00000000);
    axw(RPP_OFF_STATUS, 32'hffffffff);
    chk(32'(rsp), 32'(RPP_RESP_OKAY));
    axr(8'h10);
    chk({rd_d[31:2], rsp}, {30'h0, RPP_RESP_SLVERR});
    axw(8'h10, 32'hffffffff);
    chk(32'(rsp), 32'(RPP_RESP_SLVERR));
    // default policy: read multiple, three extra lines, continuous on
    run(RPP_CMD_MRM, 32'h104, 1'b0, 1'b0, 2, 4, 6);
    run(RPP_CMD_MRM, 32'h104, 1'b1, 1'b0, 2, 0, 0);
    run(RPP_CMD_MRM, 32'h104, 1'b0, 1'b1, 2, 0, 0);
    run(4'h7, 32'h104, 1'b0, 1'b0, 2, 0, 0);
    // only byte lane 0 written: bits 7:2 set, upper fields kept
    axw(RPP_OFF_POLICY, 32'hffffffff, 4'h1);
    axr(RPP_OFF_POLICY);
    chk(rd_d, 32'h00002cfc);
    axw(RPP_OFF_POLICY, 32'hffffffff);
    axr(RPP_OFF_POLICY);
    chk(rd_d, 32'h00003ffc);
    // line: 7 extra, no continuous; plain: 2 extra, continuous; multiple: none
    axw(RPP_OFF_POLICY, 32'h000001e8);
    chk(32'(rsp), 32'(RPP_RESP_OKAY));
    run(RPP_CMD_MRL, 32'h200, 1'b0, 1'b0, 2, 8, 8);
    slow <= 1'b1;
    run(RPP_CMD_MR, 32'h13f, 1'b0, 1'b0, 2, 3, 5);
    slow <= 1'b0;
    run(RPP_CMD_MRM, 32'h3c0, 1'b0, 1'b0, 2, 1, 1);
    results();
  end
endmodule
